// ==== chip_fault_supervisor.sv ====
// chip fault supervisor: power-on sequencing, mcu reset, overheat, serial error, nvm check
// assumes a serial front end and nvm array on aclk; supply and temperature levels are async
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module chip_fault_supervisor #(
  parameter int RST_HOLD_CYC = fault_sup_pkg::RST_HOLD_MS * (fault_sup_pkg::CLK_HZ / 1000),
  parameter int WD_HOLD_CYC = fault_sup_pkg::WD_HOLD_MS * (fault_sup_pkg::CLK_HZ / 1000),
  parameter int NVM_WORDS = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [fault_sup_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fault_sup_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // async monitor levels
  input wire logic logic_supply_ok,
  input wire logic io_supply_ok,
  input wire logic ext_supply_ok,
  input wire logic overtemp_in,
  input wire logic watchdog_kick_in,
  // serial front end (aclk)
  input wire fault_sup_pkg::ser_report_s ser_report,
  input wire logic nvm_save_busy,
  // nvm read port (aclk, data one cycle after request)
  output logic nvm_rd_en,
  output logic [7:0] nvm_addr,
  input wire logic nvm_rd_valid,
  input wire logic [fault_sup_pkg::NVM_CW_W-1:0] nvm_rd_data,
  // outputs to the chip
  output fault_sup_pkg::cfg_wr_s cfg_wr,
  output logic regs_reset,
  output logic ser_commit,
  output logic ser_clear_ok,
  output logic mcu_reset_out_n,
  output logic gate_enable,
  output logic ext_logic_regulator,
  output logic logic_inputs_enable,
  output logic wd_timer_reset,
  output logic general_fault_n
);
  import fault_sup_pkg::*;

  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_HOLD_CYC - 1);
  localparam logic [7:0] NVM_LAST = 8'(NVM_WORDS - 1);

  typedef struct packed {
    fsm_e state;
    logic [CNT_W-1:0] cnt;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic kick_prev;
    logic wd_mask;
    logic shutdown_sel;
    logic read_hold;
    logic por_flag;
    logic overheat_flag;
    logic transfer_error_flag;
    logic nvm_error_flag;
    logic [7:0] nvm_idx;
    logic nvm_pend;
    logic nvm_rd_en;
    logic [7:0] nvm_addr;
    cfg_wr_s cfg_wr;
    logic regs_reset;
    logic ser_commit;
    logic ser_clear_ok;
    logic mcu_reset_out_n;
    logic gate_enable;
    logic ext_logic_regulator;
    logic logic_inputs_enable;
    logic wd_timer_reset;
    logic general_fault_n;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ----------------------------------------
  // nvm word check: hamming plus overall parity
  // ----------------------------------------
  function automatic logic [4:0] ham_syn(input logic [NVM_CW_W-1:0] cw);
    logic [4:0] s;
    s = 5'h0;
    for (int i = 1; i < NVM_CW_W; i++) begin
      if (cw[i]) s = s ^ 5'(i);
    end
    return s;
  endfunction

  function automatic logic [NVM_DATA_W-1:0] ham_data(input logic [NVM_CW_W-1:0] cw);
    logic [NVM_DATA_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int i = 3; i < NVM_CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = cw[i];
        k++;
      end
    end
    return d;
  endfunction

  function automatic logic [31:0] status_word(input state_s s);
    logic [31:0] w;
    w = 32'h0;
    w[ST_ANY_FAULT] = s.por_flag | s.overheat_flag | s.transfer_error_flag | s.nvm_error_flag;
    w[ST_POR] = s.por_flag;
    w[ST_OVERHEAT] = s.overheat_flag;
    w[ST_XFER_ERR] = s.transfer_error_flag;
    w[ST_NVM_ERR] = s.nvm_error_flag;
    return w;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic vdd_ok, vio_ok, vlr_ok, ot_now, kick_rise;
  logic ser_valid, ser_err, clr, op_state;
  logic [4:0] syn;
  logic [NVM_CW_W-1:0] fixed;
  logic aw_go, w_go, ar_go;

  // only sync2 is read; sync1 feeds nothing else
  assign vdd_ok = st_reg.sync2[SY_VDD];
  assign vio_ok = st_reg.sync2[SY_VIO];
  assign vlr_ok = st_reg.sync2[SY_VLR];
  assign ot_now = st_reg.sync2[SY_OT];
  assign kick_rise = st_reg.sync2[SY_KICK] & ~st_reg.kick_prev;
  assign ser_valid = ser_report.done && ser_report.edges == SER_EDGES_OK
    && ser_report.parity_odd && !nvm_save_busy;
  assign ser_err = ser_report.done & ~ser_valid;
  assign op_state = !(st_reg.state inside {S_DOWN, S_NVM, S_NVM_FAULT});
  assign aw_go = s_axi_awvalid & st_reg.awready;
  assign w_go = s_axi_wvalid & st_reg.wready;
  assign ar_go = s_axi_arvalid & st_reg.arready;

  always_comb begin
    st_next = st_reg;
    syn = ham_syn(nvm_rd_data);
    fixed = nvm_rd_data;
    st_next.sync1 = {watchdog_kick_in, overtemp_in, ext_supply_ok, io_supply_ok, logic_supply_ok};
    st_next.sync2 = st_reg.sync1;
    st_next.kick_prev = st_reg.sync2[SY_KICK];
    st_next.regs_reset = 1'b0;
    st_next.nvm_rd_en = 1'b0;
    st_next.cfg_wr.en = 1'b0;
    // cancelled transfer commits nothing and clears nothing
    st_next.ser_commit = ser_valid & ser_report.is_write;
    st_next.ser_clear_ok = ser_valid & ser_report.is_diag_read;
    // status clear by a good status read, unless the hold bit is set
    clr = ((ser_valid & ser_report.is_status_read)
      | (ar_go && s_axi_araddr == ADDR_STATUS)) & ~st_reg.read_hold;
    // set wins over clear
    st_next.overheat_flag = ot_now | (st_reg.overheat_flag & ~clr);
    st_next.transfer_error_flag = ser_err | (st_reg.transfer_error_flag & ~clr);
    st_next.por_flag = st_reg.por_flag & ~clr;
    // nvm error has no register clear path
    st_next.nvm_error_flag = st_reg.nvm_error_flag;

    // counters run on the chip clock only
    st_next.cnt = st_reg.cnt + 1'b1;
    case (st_reg.state)
      S_DOWN: begin
        st_next.cnt = '0;
        if (vdd_ok) begin
          st_next.state = S_NVM;
          st_next.regs_reset = 1'b1;
          {st_next.read_hold, st_next.shutdown_sel, st_next.wd_mask} = CTRL_RESET;
          st_next.overheat_flag = ot_now;
          st_next.transfer_error_flag = 1'b0;
          st_next.nvm_error_flag = 1'b0;
          st_next.por_flag = 1'b1;
          st_next.nvm_idx = 8'h0;
          st_next.nvm_pend = 1'b0;
        end
      end
      S_NVM: begin
        if (!st_reg.nvm_pend) begin
          st_next.nvm_rd_en = 1'b1;
          st_next.nvm_addr = st_reg.nvm_idx;
          st_next.nvm_pend = 1'b1;
        end else if (nvm_rd_valid) begin
          st_next.nvm_pend = 1'b0;
          if (^nvm_rd_data) begin
            // odd overall parity: one flipped bit, correct it
            if (syn == 5'h0) fixed[0] = ~fixed[0];
            else if (syn < 5'(NVM_CW_W)) fixed[syn] = ~fixed[syn];
          end
          if ((!(^nvm_rd_data) && syn != 5'h0) || (^nvm_rd_data && syn >= 5'(NVM_CW_W))) begin
            st_next.state = S_NVM_FAULT;
            st_next.nvm_error_flag = 1'b1;
          end else begin
            st_next.cfg_wr.en = 1'b1;
            st_next.cfg_wr.addr = st_reg.nvm_idx;
            st_next.cfg_wr.data = ham_data(fixed);
            st_next.nvm_idx = st_reg.nvm_idx + 1'b1;
            if (st_reg.nvm_idx == NVM_LAST) begin
              st_next.state = S_RST_HOLD;
              st_next.cnt = '0;
            end
          end
        end
      end
      S_NVM_FAULT: st_next.cnt = '0;
      S_RST_HOLD: begin
        // the 10 ms starts only once the external supply is good
        if (!vlr_ok) st_next.cnt = '0;
        if (st_reg.wd_mask && ser_valid) begin
          st_next.state = S_RUN;
        end else if (vlr_ok && st_reg.cnt == RST_LAST) begin
          st_next.cnt = '0;
          st_next.state = st_reg.wd_mask ? S_MASK_WAIT : S_WD_HOLD;
        end
      end
      S_WD_HOLD: begin
        if (st_reg.cnt == WD_LAST) begin
          st_next.state = S_WAIT_KICK;
        end
      end
      S_WAIT_KICK: begin
        if (kick_rise) st_next.state = S_RUN;
      end
      S_MASK_WAIT: begin
        if (ser_valid || st_reg.cnt == RST_LAST) st_next.state = S_RUN;
      end
      S_RUN: st_next.cnt = '0;
      S_OT_OFF: begin
        st_next.cnt = '0;
        if (!ot_now) st_next.state = S_RST_HOLD;
      end
      default: st_next.state = S_DOWN;
    endcase
    // select 0 leaves the shutdown path untaken
    if (op_state && ot_now && st_reg.shutdown_sel) begin
      st_next.state = S_OT_OFF;
      st_next.cnt = '0;
    end
    // no control bit can mask the logic supply lockout
    if (!vdd_ok) begin
      st_next.state = S_DOWN;
      st_next.cnt = '0;
    end

    // ----------------------------------------
    // pin outputs follow the next state
    // ----------------------------------------
    st_next.gate_enable = (st_next.state == S_RUN) && vio_ok;
    st_next.mcu_reset_out_n = !(st_next.state inside {S_DOWN, S_NVM, S_NVM_FAULT, S_RST_HOLD,
      S_OT_OFF});
    st_next.ext_logic_regulator = st_next.state != S_OT_OFF && st_next.state != S_DOWN;
    st_next.wd_timer_reset = st_next.state == S_WD_HOLD || st_next.mcu_reset_out_n == 1'b0;
    st_next.logic_inputs_enable = vio_ok && st_next.state != S_DOWN;
    st_next.general_fault_n = !(ot_now || st_next.nvm_error_flag);

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    if (aw_go) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (w_go) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) st_next.bvalid = 1'b0;
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (st_reg.aw_addr == ADDR_CTRL) begin
        if (st_reg.w_strb[0] && st_reg.state != S_DOWN) begin
          st_next.wd_mask = st_reg.w_data[CTRL_WD_MASK];
          st_next.shutdown_sel = st_reg.w_data[CTRL_SHUTDOWN_SEL];
          st_next.read_hold = st_reg.w_data[CTRL_READ_HOLD];
        end
      end else if (st_reg.aw_addr != ADDR_STATUS && st_reg.aw_addr != ADDR_STATE) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready = !st_next.w_full && !st_next.bvalid;

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    if (s_axi_rvalid && s_axi_rready) st_next.rvalid = 1'b0;
    if (ar_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: st_next.rdata = {29'h0, st_reg.read_hold, st_reg.shutdown_sel, st_reg.wd_mask};
        ADDR_STATUS: st_next.rdata = status_word(st_reg);
        ADDR_STATE: st_next.rdata = {16'h0, 4'(st_reg.state), 6'h0, st_reg.logic_inputs_enable,
          st_reg.wd_timer_reset, st_reg.ext_logic_regulator, st_reg.general_fault_n,
          st_reg.gate_enable, st_reg.mcu_reset_out_n};
        default: begin
          st_next.rdata = 32'h0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_reg <= '0;
    else st_reg <= st_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign nvm_rd_en = st_reg.nvm_rd_en;
  assign nvm_addr = st_reg.nvm_addr;
  assign cfg_wr = st_reg.cfg_wr;
  assign regs_reset = st_reg.regs_reset;
  assign ser_commit = st_reg.ser_commit;
  assign ser_clear_ok = st_reg.ser_clear_ok;
  assign mcu_reset_out_n = st_reg.mcu_reset_out_n;
  assign gate_enable = st_reg.gate_enable;
  assign ext_logic_regulator = st_reg.ext_logic_regulator;
  assign logic_inputs_enable = st_reg.logic_inputs_enable;
  assign wd_timer_reset = st_reg.wd_timer_reset;
  assign general_fault_n = st_reg.general_fault_n;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = vdd_ok && !(ot_now && st_reg.shutdown_sel);
  logic [31:0] status_now;
  assign status_now = status_word(st_reg);

  sequence s_released;
    mcu_reset_out_n && !gate_enable;
  endsequence
  sequence s_gates_on;
    gate_enable || !vio_ok;
  endsequence

  property p_down_gates_off;
    !vdd_ok |=> !gate_enable && !mcu_reset_out_n && st_reg.state == S_DOWN;
  endproperty
  a_down_gates_off: assert property (p_down_gates_off) else $error("gates on in power down");

  property p_por_flags;
    st_reg.state == S_DOWN && vdd_ok |=> status_now[ST_ANY_FAULT] && st_reg.por_flag;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-up flags not set");

  property p_wd_hold_ignores_kick;
    st_reg.state == S_WD_HOLD && st_reg.cnt != WD_LAST && quiet |=> st_reg.state == S_WD_HOLD;
  endproperty
  a_wd_hold_ignores_kick: assert property (p_wd_hold_ignores_kick) else $error("hold left early");

  property p_kick_needed;
    st_reg.state == S_WAIT_KICK && !kick_rise |=> !gate_enable;
  endproperty
  a_kick_needed: assert property (p_kick_needed) else $error("gates on before kick");

  property p_masked_serial;
    st_reg.state == S_RST_HOLD && st_reg.wd_mask && ser_valid && quiet
      |=> mcu_reset_out_n && (gate_enable || !vio_ok);
  endproperty
  a_masked_serial: assert property (p_masked_serial) else $error("transfer did not release");

  property p_unmasked_release;
    st_reg.state == S_RST_HOLD && !st_reg.wd_mask && vlr_ok && st_reg.cnt == RST_LAST && quiet
      |=> s_released ##1 wd_timer_reset;
  endproperty
  a_unmasked_release: assert property (p_unmasked_release) else $error("bad reset release");

  property p_mask_wait_end;
    st_reg.state == S_MASK_WAIT && st_reg.cnt == RST_LAST && quiet |=> s_gates_on;
  endproperty
  a_mask_wait_end: assert property (p_mask_wait_end) else $error("gates late after wait");

  property p_ot_shutdown;
    op_state && ot_now && st_reg.shutdown_sel && vdd_ok
      |=> !gate_enable && !ext_logic_regulator && !mcu_reset_out_n && !general_fault_n;
  endproperty
  a_ot_shutdown: assert property (p_ot_shutdown) else $error("overheat shutdown missing");

  property p_overheat_latched;
    st_reg.overheat_flag && !clr && st_reg.state != S_DOWN |=> st_reg.overheat_flag;
  endproperty
  a_overheat_latched: assert property (p_overheat_latched) else $error("overheat flag lost");

  property p_ser_cancel;
    ser_err |=> st_reg.transfer_error_flag && !ser_commit && !ser_clear_ok;
  endproperty
  a_ser_cancel: assert property (p_ser_cancel) else $error("bad transfer not cancelled");

  property p_nvm_multi;
    st_reg.state == S_NVM && st_reg.nvm_pend && nvm_rd_valid && !(^nvm_rd_data)
      && syn != 5'h0 && vdd_ok |=> st_reg.nvm_error_flag && !gate_enable && !general_fault_n;
  endproperty
  a_nvm_multi: assert property (p_nvm_multi) else $error("nvm multi-bit not handled");

  property p_nvm_sticky;
    st_reg.nvm_error_flag && st_reg.state != S_DOWN |=> st_reg.nvm_error_flag;
  endproperty
  a_nvm_sticky: assert property (p_nvm_sticky) else $error("nvm error cleared");

endmodule // chip_fault_supervisor

// ==== fault_sup_pkg.sv ====
// fault supervisor package: register map, field positions, timing and carriers
// assumes a single 125 MHz chip clock shared by all users of these definitions
package fault_sup_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int RST_HOLD_MS = 10;
  localparam int WD_HOLD_MS = 100;
  localparam int CNT_W = 24;

  // ----------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam int CTRL_WD_MASK = 0;
  localparam int CTRL_SHUTDOWN_SEL = 1;
  localparam int CTRL_READ_HOLD = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int ST_ANY_FAULT = 15;
  localparam int ST_POR = 14;
  localparam int ST_OVERHEAT = 13;
  localparam int ST_XFER_ERR = 12;
  localparam int ST_NVM_ERR = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // synchroniser lanes, serial and nvm figures
  // ----------------------------------------
  localparam int SY_VDD = 0;
  localparam int SY_VIO = 1;
  localparam int SY_VLR = 2;
  localparam int SY_OT = 3;
  localparam int SY_KICK = 4;
  localparam logic [5:0] SER_EDGES_OK = 6'h10;
  localparam int NVM_CW_W = 22;
  localparam int NVM_DATA_W = 16;

  typedef enum logic [3:0] {
    S_DOWN, S_NVM, S_NVM_FAULT, S_RST_HOLD, S_WD_HOLD, S_WAIT_KICK, S_MASK_WAIT, S_RUN,
    S_OT_OFF
  } fsm_e;

  typedef struct packed {
    logic done;
    logic [5:0] edges;
    logic parity_odd;
    logic is_write;
    logic is_diag_read;
    logic is_status_read;
  } ser_report_s;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [NVM_DATA_W-1:0] data;
  } cfg_wr_s;

endpackage

// ==== nvm_model.sv ====
// nvm array model for the supervisor's read port
// assumes aclk domain; nvm_err 1 flips one bit, 2 flips two
`timescale 1ns/1ps
module nvm_model (
  // clock
  input wire logic aclk,
  // read port
  input wire logic nvm_rd_en,
  input wire logic [1:0] nvm_err,
  output logic nvm_rd_valid,
  output logic [21:0] nvm_rd_data
);
  // ----
  // answer
  // ----
  // all-zero word is a clean codeword; idle bus shows the inverse, not a stale word
  always_ff @(posedge aclk) begin
    nvm_rd_valid <= nvm_rd_en;
    nvm_rd_data <= nvm_rd_en ? {16'h0000, nvm_err[1], 1'h0, |nvm_err, 3'h0} : ~nvm_rd_data;
  end
endmodule // nvm_model

// ==== chip_fault_supervisor_tb.sv ====
// bench for the fault supervisor: axi tasks, serial reports, supply and heat steps
// assumes the nvm model is compiled first; hold counts shortened by parameters
`timescale 1ns/1ps
module chip_fault_supervisor_tb;
  import fault_sup_pkg::*;
  // ----
  // signals and instances
  // ----
  logic aclk = '0, aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, nvm_addr;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
  logic s_axi_bready = '1, s_axi_rready = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, nvm_err = '0;
  logic logic_supply_ok = '0, io_supply_ok = '0, ext_supply_ok = '0, ext_on = '0;
  logic overtemp_in = '0, watchdog_kick_in = '0, nvm_save_busy = '0, nvm_rd_en, nvm_rd_valid;
  logic regs_reset, ser_commit, ser_clear_ok, mcu_reset_out_n, gate_enable, wd_timer_reset;
  logic ext_logic_regulator, logic_inputs_enable, general_fault_n;
  logic [21:0] nvm_rd_data;
  ser_report_s ser_report = '0;
  cfg_wr_s cfg_wr;
  int n_mismatch = 0, n_compared = 0, n_cfg = 0, cyc = 0, c;
  logic [5:0] te[4] = '{6'h11, 6'h0F, 6'h10, 6'h10};
  logic tp[4] = '{1'h1, 1'h1, 1'h0, 1'h1};
  logic tb[4] = '{1'h0, 1'h0, 1'h0, 1'h1};
  logic [2:0] tk[4] = '{3'h4, 3'h2, 3'h1, 3'h4};

  chip_fault_supervisor #(.RST_HOLD_CYC(20), .WD_HOLD_CYC(50), .NVM_WORDS(2))
    u_chip_fault_supervisor (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .logic_supply_ok, .io_supply_ok, .ext_supply_ok,
    .overtemp_in, .watchdog_kick_in, .ser_report, .nvm_save_busy, .nvm_rd_en, .nvm_addr,
    .nvm_rd_valid, .nvm_rd_data, .cfg_wr, .regs_reset, .ser_commit, .ser_clear_ok,
    .mcu_reset_out_n, .gate_enable, .ext_logic_regulator, .logic_inputs_enable,
    .wd_timer_reset, .general_fault_n);
  nvm_model u_nvm_model (.aclk, .nvm_rd_en, .nvm_err, .nvm_rd_valid, .nvm_rd_data);

  // ----
  // tasks
  // ----
  task automatic cmp(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic upto(ref logic s, input logic v);
    c = 0;
    while (s !== v && c < 3000) begin
      @(posedge aclk);
      c++;
    end
    if (c >= 3000) n_mismatch++;
  endtask
  // both channels offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (s_axi_bvalid !== '1);
    cmp("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    do @(posedge aclk); while (s_axi_arready !== '1);
    s_axi_arvalid <= '0;
    do @(posedge aclk); while (s_axi_rvalid !== '1);
    d = s_axi_rdata;
    cmp("rresp", r, s_axi_rresp);
  endtask
  task automatic ser(input logic [5:0] e, input logic p, b, input logic [2:0] k, input logic x);
    ser_report <= {1'h1, e, p, k};
    nvm_save_busy <= b;
    clk(1);
    ser_report <= '0;
    nvm_save_busy <= '0;
    clk(1);
    cmp("commit", x, ser_commit | ser_clear_ok);
  endtask

  initial forever #4 aclk = ~aclk;
  // regulator feeds the external supply; timeout ends a hang
  always @(posedge aclk) begin
    cyc++;
    ext_supply_ok <= ext_logic_regulator & ext_on;
    if (nvm_rd_en === 1'b1) cmp("nvm addr", n_cfg % 2, nvm_addr);
    if (cfg_wr.en === '1) begin
      cmp("cfg addr", n_cfg % 2, cfg_wr.addr);
      n_cfg++;
      cmp("cfg", '0, cfg_wr.data);
    end
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    clk(16);
    aresetn <= '1;
    clk(2);
    cmp("rst", 3'h1, {mcu_reset_out_n, gate_enable, general_fault_n});
    nvm_err <= 2'h1;
    logic_supply_ok <= '1;
    upto(regs_reset, '1);
    cmp("regs_reset", 32'h1, regs_reset);
    clk(20);
    cmp("cfg count", 2, n_cfg);
    cmp("inputs off", '0, logic_inputs_enable);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("status", 32'hC000, d & 32'hF800);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("por clr", '0, d[ST_POR]);
    rd(8'h0C, RESP_SLVERR);
    io_supply_ok <= '1;
    ext_on <= '1;
    upto(mcu_reset_out_n, '1);
    cmp("rst hold", 32'h1, c >= 20 && c <= 28);
    cmp("inputs on", 32'h1, logic_inputs_enable);
    clk(2);
    cmp("wd reset", 32'h1, wd_timer_reset);
    watchdog_kick_in <= '1;
    clk(10);
    watchdog_kick_in <= '0;
    upto(wd_timer_reset, '0);
    cmp("wd hold", 32'h1, c >= 35 && c <= 42);
    cmp("gate early", '0, gate_enable);
    clk(4);
    watchdog_kick_in <= '1;
    upto(gate_enable, '1);
    cmp("kick", 32'h1, c < 8);
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    overtemp_in <= '1;
    clk(6);
    cmp("hot", '0, {gate_enable, ext_logic_regulator, mcu_reset_out_n, general_fault_n});
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("overheat", 32'h1, d[ST_OVERHEAT]);
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    overtemp_in <= '0;
    upto(ext_logic_regulator, '1);
    cmp("cool", 32'h1, c < 8);
    upto(mcu_reset_out_n, '1);
    cmp("rst again", 32'h1, c >= 20 && c <= 28);
    upto(gate_enable, '1);
    cmp("masked gate", 32'h1, c >= 18 && c <= 22);
    overtemp_in <= '1;
    clk(6);
    overtemp_in <= '0;
    upto(ext_logic_regulator, '1);
    clk(6);
    ser(6'h10, '1, '0, 3'h4, '1);
    clk(1);
    cmp("early rel", 2'h3, {mcu_reset_out_n, gate_enable});
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    overtemp_in <= '1;
    clk(6);
    cmp("hot keep", 4'hE, {gate_enable, ext_logic_regulator, mcu_reset_out_n, general_fault_n});
    overtemp_in <= '0;
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("held", 32'h1, d[ST_OVERHEAT]);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("cleared", '0, d[ST_OVERHEAT]);
    for (int i = 0; i < 4; i++) ser(te[i], tp[i], tb[i], tk[i], '0);
    ser(6'h10, 1'h1, 1'h0, 3'h2, 1'h1);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("xfer err", 32'h1, d[ST_XFER_ERR]);
    logic_supply_ok <= '0;
    clk(5);
    cmp("down", '0, gate_enable);
    nvm_err <= 2'h2;
    logic_supply_ok <= '1;
    clk(30);
    cmp("nvm off", '0, {gate_enable, general_fault_n});
    rd(ADDR_STATUS, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("nvm err", 32'h1, d[ST_NVM_ERR]);
    logic_supply_ok <= '0;
    nvm_err <= '0;
    clk(5);
    logic_supply_ok <= '1;
    clk(30);
    rd(ADDR_CTRL, RESP_OKAY);
    cmp("ctrl por", '0, d);
    rd(ADDR_STATUS, RESP_OKAY);
    cmp("nvm clr", '0, d[ST_NVM_ERR]);
    finish_test;
  end
endmodule // chip_fault_supervisor_tb
